// ### sim/sas_adc_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sas_adc_seq_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, comp, standby = 1'b0;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   sas_pkg::sas_ana_t ana;
   logic [3:0][9:0] vin = 40'h0;
   int seed = 26;
   int n_mismatch = 0;
   int n_tests = 0;
   int n, ch;
   // Only the permitted time codes are used
   int tcode [8] = '{0, 1, 2, 4, 5, 6, 1, 4};
   int tclk [8] = '{144, 120, 96, 72, 60, 48, 120, 72};

   always #2.5 aclk = ~aclk;

   sas_adc_seq i_sas_adc_seq (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .standby(standby), .comp_above(comp), .ana_ctl_q(ana),
      .conv_done_irq(irq));

   sas_ana_model i_sas_ana_model (.aclk(aclk), .ana_ctl(ana), .vin(vin), .comp_above(comp));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      n_mismatch++;
      print_verdict();
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      int i;
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100 && !done; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang();
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] v);
      int i;
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100 && !done; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            check(rresp, sas_pkg::RESP_OKAY);
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hang();
   endtask

   // Cycles from the call until the completion pulse
   task automatic wait_irq(input int lim, output int cnt);
      for (cnt = 1; cnt <= lim; cnt++) begin
         @(posedge aclk);
         if (irq === 1'b1) return;
      end
      hang();
   endtask

   task automatic no_irq(input int cyc);
      logic bad;
      bad = 1'b0;
      repeat (cyc) begin
         @(posedge aclk);
         if (irq !== 1'b0) bad = 1'b1;
      end
      check(bad, 0);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(sas_pkg::MODE_OFS, d);
      check(d, 0);
      axi_read(sas_pkg::CHAN_OFS, d);
      check(d, 0);
      axi_read(sas_pkg::STATUS_OFS, d);
      check(d, 0);
      no_irq(200);
      for (int c = 0; c < 8; c++) begin
         ch = $random(seed) & 3;
         for (int k = 0; k < 4; k++) vin[k] <= 10'($random(seed));
         axi_write(sas_pkg::CHAN_OFS, 32'(ch), r);
         axi_write(sas_pkg::MODE_OFS, 32'h80 | 32'(tcode[c] << sas_pkg::TSEL_LSB), r);
         check(r, sas_pkg::RESP_OKAY);
         // first result after a start is not trusted
         wait_irq(400, n);
         check(ana.chan, ch);
         wait_irq(400, n);
         check(n, tclk[c]);
         // result read while the converter runs
         axi_read(sas_pkg::RESULT_OFS, d);
         check(d, vin[ch]);
      end
      axi_read(sas_pkg::STATUS_OFS, d);
      check(d[0], 1);
      axi_write(sas_pkg::MODE_OFS, 32'h80, r);
      axi_read(sas_pkg::STATUS_OFS, d);
      check(d[0], 1);
      wait_irq(400, n);
      repeat (70) @(posedge aclk);
      ch = (ch + 1) & 3;
      axi_write(sas_pkg::CHAN_OFS, 32'(ch), r);
      wait_irq(400, n);
      check(n >= 130, 1);
      axi_read(sas_pkg::RESULT_OFS, d);
      check(d, vin[ch]);
      axi_write(sas_pkg::STATUS_OFS, 32'h1, r);
      axi_read(sas_pkg::STATUS_OFS, d);
      check(d[0], 0);
      standby <= 1'b1;
      no_irq(300);
      check(ana.hold, 0);
      standby <= 1'b0;
      wait_irq(400, n);
      axi_write(sas_pkg::MODE_OFS, 32'h0, r);
      axi_read(sas_pkg::RESULT_OFS, d);
      check(d, vin[ch]);
      no_irq(300);
      check(ana.hold, 0);
      axi_write(sas_pkg::RESULT_OFS, 32'h0, r);
      check(r, sas_pkg::RESP_SLVERR);
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge aclk);
      hang();
   end
endmodule

`default_nettype wire

// ### sim/sas_ana_model.sv
`timescale 1ns/1ps
`default_nettype none

module sas_ana_model (
   input wire logic aclk,
   input wire sas_pkg::sas_ana_t ana_ctl,
   input wire logic [3:0][9:0] vin,
   output logic comp_above
);
   logic [9:0] held_q;
   logic toggle_q = 1'b0;

   always @(posedge aclk) begin
      if (!ana_ctl.hold) begin
         held_q <= vin[ana_ctl.chan];
      end
      toggle_q <= ~toggle_q;
   end

   // input >= tap reads high
   // Toggles while sampling, so no stale answer can pass for a real one
   assign comp_above = ana_ctl.hold ? (held_q >= ana_ctl.tap) : toggle_q;
endmodule

`default_nettype wire

// ### verilog/sas_adc_seq.sv
`timescale 1ns/1ps
`default_nettype none

module sas_adc_seq (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic standby,
   input wire logic comp_above,
   output sas_pkg::sas_ana_t ana_ctl_q,
   output logic conv_done_irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // prohibited codes fall back to the slowest time, never faster
   function automatic logic [7:0] conv_clks(input logic [2:0] sel);
      case (sel)
         3'h0: conv_clks = sas_pkg::T000_CLKS;
         3'h1: conv_clks = sas_pkg::T001_CLKS;
         3'h2: conv_clks = sas_pkg::T010_CLKS;
         3'h4: conv_clks = sas_pkg::T100_CLKS;
         3'h5: conv_clks = sas_pkg::T101_CLKS;
         3'h6: conv_clks = sas_pkg::T110_CLKS;
         default: conv_clks = sas_pkg::T000_CLKS;
      endcase
   endfunction

   function automatic logic is_reg(input logic [3:0] addr, input logic [3:0] ofs);
      is_reg = (addr[3:2] == ofs[3:2]);
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_full_q, w_full_q, aw_full_d, w_full_d, wr_fire;
   logic awready_q, wready_q, bvalid_q;
   logic [1:0] bresp_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_mode, wr_chan, wr_any, wr_stat;

   assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
   assign aw_full_d = (aw_full_q | (s_axi_awvalid & awready_q)) & ~wr_fire;
   assign w_full_d = (w_full_q | (s_axi_wvalid & wready_q)) & ~wr_fire;
   assign wr_mode = wr_fire & wstrb_q[0] & is_reg(awaddr_q, sas_pkg::MODE_OFS);
   assign wr_chan = wr_fire & wstrb_q[0] & is_reg(awaddr_q, sas_pkg::CHAN_OFS);
   assign wr_stat = wr_fire & wstrb_q[0] & is_reg(awaddr_q, sas_pkg::STATUS_OFS);
   assign wr_any = wr_mode | wr_chan;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= sas_pkg::RESP_OKAY;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready_q <= ~aw_full_d;
         wready_q <= ~w_full_d;
         if (s_axi_awvalid && awready_q) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_reg(awaddr_q, sas_pkg::RESULT_OFS) ? sas_pkg::RESP_SLVERR
                                                              : sas_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [7:0] mode_q;
   logic [1:0] chan_q;
   logic [9:0] result_q;
   logic pend_q;
   logic done_evt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= sas_pkg::MODE_RST;
         chan_q <= sas_pkg::CHAN_RST;
      end else begin
         if (wr_mode) begin
            mode_q <= wdata_q[7:0] & sas_pkg::MODE_MASK;
         end
         if (wr_chan) begin
            chan_q <= wdata_q[1:0];
         end
      end
   end

   // only completion and software clear touch the flag; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= 1'b0;
      end else if (done_evt) begin
         pend_q <= 1'b1;
      end else if (wr_stat && wdata_q[sas_pkg::PEND_BIT]) begin
         pend_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   sas_pkg::sas_state_t state_q;
   logic [7:0] cnt_q, sample_clks;
   logic [3:0] bit_q;
   logic [9:0] approx_q, approx_nx;
   logic hold_q, irq_q, en_after, step_end;

   assign sample_clks = conv_clks(mode_q[sas_pkg::TSEL_LSB +: 3]) - sas_pkg::CONV_CLKS;
   assign en_after = wr_mode ? wdata_q[sas_pkg::ENABLE_BIT] : mode_q[sas_pkg::ENABLE_BIT];
   assign step_end = (state_q == sas_pkg::SAS_CONVERT) && (cnt_q == sas_pkg::STEP_CLKS - 8'h01);
   // a colliding mode or channel write, or standby, suppresses the update
   assign done_evt = step_end && (bit_q == 4'h0) && !wr_any && !standby;

   // keep or drop the trial bit; set the next one
   always_comb begin
      approx_nx = approx_q;
      if (!comp_above) begin
         approx_nx[bit_q] = 1'b0;
      end
      if (bit_q != 4'h0) begin
         approx_nx[bit_q - 4'h1] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= sas_pkg::SAS_IDLE;
         cnt_q <= 8'h00;
         bit_q <= 4'h0;
         approx_q <= 10'h000;
         hold_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= done_evt;
         if (standby) begin
            state_q <= sas_pkg::SAS_IDLE;
            hold_q <= 1'b0;
            cnt_q <= 8'h00;
         end else if (wr_any) begin
            // abort and restart; halt when enable cleared
            state_q <= en_after ? sas_pkg::SAS_SAMPLE : sas_pkg::SAS_IDLE;
            hold_q <= 1'b0;
            cnt_q <= 8'h00;
         end else begin
            case (state_q)
               sas_pkg::SAS_IDLE: begin
                  // only the enable bit starts a conversion
                  if (mode_q[sas_pkg::ENABLE_BIT]) begin
                     state_q <= sas_pkg::SAS_SAMPLE;
                  end
                  cnt_q <= 8'h00;
               end
               sas_pkg::SAS_SAMPLE: begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == sample_clks - 8'h01) begin
                     // hold; first trial at half reference
                     state_q <= sas_pkg::SAS_CONVERT;
                     hold_q <= 1'b1;
                     approx_q <= sas_pkg::MSB_TRIAL;
                     bit_q <= 4'(sas_pkg::RES_BITS - 1);
                     cnt_q <= 8'h00;
                  end
               end
               sas_pkg::SAS_CONVERT: begin
                  cnt_q <= cnt_q + 8'h01;
                  if (step_end) begin
                     cnt_q <= 8'h00;
                     approx_q <= approx_nx;
                     bit_q <= bit_q - 4'h1;
                     if (bit_q == 4'h0) begin
                        state_q <= sas_pkg::SAS_SAMPLE;
                        hold_q <= 1'b0;
                        bit_q <= 4'h0;
                     end
                  end
               end
               default: state_q <= sas_pkg::SAS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (done_evt) begin
         result_q <= approx_nx;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic arready_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // rdata samples result_q before this edge's update lands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= sas_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         rvalid_q <= 1'b1;
         arready_q <= 1'b0;
         rresp_q <= sas_pkg::RESP_OKAY;
         rdata_q <= 32'h0;
         if (is_reg(s_axi_araddr, sas_pkg::MODE_OFS)) begin
            rdata_q <= {24'h0, mode_q};
         end else if (is_reg(s_axi_araddr, sas_pkg::CHAN_OFS)) begin
            rdata_q <= {30'h0, chan_q};
         end else if (is_reg(s_axi_araddr, sas_pkg::RESULT_OFS)) begin
            rdata_q <= {22'h0, result_q};
         end else begin
            rdata_q <= {30'h0, state_q != sas_pkg::SAS_IDLE, pend_q};
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign conv_done_irq = irq_q;
   assign ana_ctl_q = '{chan: chan_q, hold: hold_q, tap: approx_q};

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence sample_to_convert;
      state_q == sas_pkg::SAS_SAMPLE ##1 state_q == sas_pkg::SAS_CONVERT;
   endsequence

   hold_in_conv_a: assert property (state_q == sas_pkg::SAS_CONVERT |-> hold_q)
      else $error("hold released during conversion");
   msb_trial_a: assert property (sample_to_convert |-> approx_q == 10'h200 && bit_q == 4'h9)
      else $error("conversion did not start at bit 9");
   trial_drop_a: assert property (step_end && !comp_above && !wr_any && !standby |=>
         approx_q[$past(bit_q)] == 1'b0)
      else $error("trial bit kept on low input");
   result_copy_a: assert property (done_evt |=> result_q == $past(approx_nx) && irq_q)
      else $error("result or interrupt missing at end");
   restart_a: assert property (done_evt && mode_q[7] |=> state_q == sas_pkg::SAS_SAMPLE)
      else $error("no restart while enabled");
   halt_a: assert property (!mode_q[sas_pkg::ENABLE_BIT] |->
         state_q == sas_pkg::SAS_IDLE)
      else $error("converter kept running after disable");
   write_wins_a: assert property (wr_any |=> !irq_q && pend_q == $past(pend_q))
      else $error("interrupt despite colliding write");
   standby_stop_a: assert property (standby |=> state_q == sas_pkg::SAS_IDLE && !hold_q)
      else $error("converter active in standby");
   pend_keep_a: assert property (wr_mode && pend_q |=> pend_q)
      else $error("mode write cleared pending flag");
   irq_pulse_a: assert property (irq_q |-> pend_q ##1 !irq_q)
      else $error("interrupt not a single pulse");

endmodule

`default_nettype wire

// ### verilog/sas_pkg.sv
package sas_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] CHAN_OFS = 4'h4;
   localparam logic [3:0] RESULT_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hc;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int ENABLE_BIT = 7;
   localparam int TSEL_LSB = 3;
   localparam int PEND_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] MODE_MASK = 8'hb8;
   localparam logic [1:0] CHAN_RST = 2'h0;

   // ----------------------------------------------------------------
   // Conversion timing in system clocks
   // ----------------------------------------------------------------
   localparam int RES_BITS = 10;
   localparam logic [9:0] MSB_TRIAL = 10'h200;
   localparam logic [7:0] STEP_CLKS = 8'h04;
   localparam logic [7:0] T000_CLKS = 8'h90;
   localparam logic [7:0] T001_CLKS = 8'h78;
   localparam logic [7:0] T010_CLKS = 8'h60;
   localparam logic [7:0] T100_CLKS = 8'h48;
   localparam logic [7:0] T101_CLKS = 8'h3c;
   localparam logic [7:0] T110_CLKS = 8'h30;
   localparam logic [7:0] CONV_CLKS = 8'h28;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_SAMPLE = 2'b01,
      SAS_CONVERT = 2'b10
   } sas_state_t;

   // Drive toward the analog front end
   typedef struct packed {
      logic [1:0] chan;
      logic hold;
      logic [9:0] tap;
   } sas_ana_t;

endpackage
